// *** core/tpr_defines.vh ***
// tpr_defines.vh: register map, fields, resets and timing
`ifndef TPR_DEFINES_VH
`define TPR_DEFINES_VH

// ----------------------------------------------------------------------------
// register indices and byte addresses (index times four)
// ----------------------------------------------------------------------------
`define TPR_IDX_CTRL_A        8'h70
`define TPR_IDX_CTRL_B        8'h71
`define TPR_IDX_X_HIGH        8'h72
`define TPR_IDX_Y_HIGH        8'h73
`define TPR_IDX_XY_LOW        8'h74
`define TPR_ADDR_CTRL_A       {2'h0, `TPR_IDX_CTRL_A, 2'h0}
`define TPR_ADDR_CTRL_B       {2'h0, `TPR_IDX_CTRL_B, 2'h0}
`define TPR_ADDR_X_HIGH       {2'h0, `TPR_IDX_X_HIGH, 2'h0}
`define TPR_ADDR_Y_HIGH       {2'h0, `TPR_IDX_Y_HIGH, 2'h0}
`define TPR_ADDR_XY_LOW       {2'h0, `TPR_IDX_XY_LOW, 2'h0}
`define TPR_ADDR_W            12

// ----------------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------------
`define TPR_A_ENABLE          7
`define TPR_A_WAIT_HI         6
`define TPR_A_WAIT_LO         4
`define TPR_A_WAKE_EN         3
`define TPR_A_DIV_HI          2
`define TPR_A_DIV_LO          0
`define TPR_B_MANUAL          6
`define TPR_B_VREF_EXT        5
`define TPR_B_DEBOUNCE        2
`define TPR_B_MODE_HI         1
`define TPR_B_MODE_LO         0
`define TPR_L_DETECT          7

// ----------------------------------------------------------------------------
// reset values and masks
// ----------------------------------------------------------------------------
`define TPR_RST_CTRL_A        8'h00
`define TPR_RST_CTRL_B        8'h00
`define TPR_RST_COORD         8'h00
`define TPR_B_WR_MASK         8'h67
`define TPR_B_RO_ONES         8'h80

// ----------------------------------------------------------------------------
// phases and timing
// ----------------------------------------------------------------------------
`define TPR_PH_IDLE           2'h0
`define TPR_PH_WAIT           2'h1
`define TPR_PH_LATX           2'h2
`define TPR_PH_LATY           2'h3
`define TPR_WAIT_BASE         512
`define TPR_WAIT_W            17
`define TPR_DEBOUNCE_CYC      16

`endif

// *** core/tpr_sample_timer.v ***
// tpr_sample_timer.v: adc data-ready wait counter
`timescale 1ns/1ps
`include "tpr_defines.vh"

module tpr_sample_timer #(
    parameter BASE = `TPR_WAIT_BASE,
    parameter W    = `TPR_WAIT_W
) (
    input  wire         clk,
    input  wire         rst_n,
    input  wire         ce,
    input  wire         start,
    input  wire [2:0]   code,
    output wire         busy,
    output reg          done
);

    reg  [W-1:0] cnt_reg;
    reg          run_reg;
    wire [W-1:0] load_val;

    // base << code cycles, minus one since the load cycle counts
    assign load_val = (BASE[W-1:0] << code) - {{(W-1){1'b0}}, 1'b1};
    assign busy     = run_reg;

    // start reloads even while running, so a re-entered phase waits in full
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_reg <= {W{1'b0}};
            run_reg <= 1'b0;
            done    <= 1'b0;
        end else if (ce) begin
            done <= 1'b0;
            if (start) begin
                cnt_reg <= load_val;
                run_reg <= 1'b1;
            end else if (run_reg) begin
                if (cnt_reg == {W{1'b0}}) begin
                    run_reg <= 1'b0;
                    done    <= 1'b1;
                end else begin
                    cnt_reg <= cnt_reg - {{(W-1){1'b0}}, 1'b1};
                end
            end
        end
    end

endmodule // tpr_sample_timer

// *** core/tpr_adc_clkdiv.v ***
// tpr_adc_clkdiv.v: adc clock tick from the system clock
`timescale 1ns/1ps

module tpr_adc_clkdiv (
    input  wire         clk,
    input  wire         rst_n,
    input  wire         ce,
    input  wire         run,
    input  wire [2:0]   code,
    output reg          tick
);

    reg  [6:0] cnt_reg;
    wire [6:0] last;

    // terminal count 2^code - 1; code 0 ticks every cycle
    assign last = (7'h01 << code) - 7'h01;

    // a one-cycle tick per adc clock period keeps the block on one clock
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_reg <= 7'h00;
            tick    <= 1'b0;
        end else if (ce) begin
            if (!run) begin
                cnt_reg <= 7'h00;
                tick    <= 1'b0;
            end else if (cnt_reg >= last) begin
                cnt_reg <= 7'h00;
                tick    <= 1'b1;
            end else begin
                cnt_reg <= cnt_reg + 7'h01;
                tick    <= 1'b0;
            end
        end
    end

endmodule // tpr_adc_clkdiv

// *** core/tpr_touch_panel_readout.v ***
// tpr_touch_panel_readout.v: touch panel readout with ahb-lite register slave
//
// Decided for this implementation: the AHB-Lite register port.
`timescale 1ns/1ps
`include "tpr_defines.vh"

module tpr_touch_panel_readout #(
    parameter WAIT_BASE    = `TPR_WAIT_BASE,
    parameter DEBOUNCE_CYC = `TPR_DEBOUNCE_CYC
) (
    input  wire         clk,
    input  wire         rstn,
    input  wire         ce,
    // ahb-lite slave
    input  wire         hsel,
    input  wire [31:0]  haddr,
    input  wire [1:0]   htrans,
    input  wire         hwrite,
    input  wire [2:0]   hsize,
    input  wire [31:0]  hwdata,
    input  wire         hready,
    output wire         hreadyout,
    output wire         hresp,
    output reg  [31:0]  hrdata,
    // panel and adc
    input  wire         touch_sense_n,
    input  wire         sleep_mode,
    input  wire [9:0]   adc_data,
    output reg          adc_enable,
    output reg          adc_run,
    output reg          adc_axis_y,
    output reg          adc_vref_ext,
    output wire         adc_clk_tick,
    output reg          touch_event,
    output reg          wake_req
);

    // ------------------------------------------------------------------------
    // reset release and pin synchronisers
    // ------------------------------------------------------------------------
    reg  rst_meta_reg;
    reg  rst_n_sync;
    reg  sense_meta_reg;
    reg  sense_sync_reg;

    // async assert, release through two flops
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rst_meta_reg <= 1'b0;
            rst_n_sync   <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_n_sync   <= rst_meta_reg;
        end
    end

    // panel sense pin; idles high so detector reads one out of reset
    always @(posedge clk or negedge rst_n_sync) begin
        if (!rst_n_sync) begin
            sense_meta_reg <= 1'b1;
            sense_sync_reg <= 1'b1;
        end else if (ce) begin
            sense_meta_reg <= touch_sense_n;
            sense_sync_reg <= sense_meta_reg;
        end
    end

    // ------------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------------
    reg  [7:0] ctrl_a_reg;
    reg  [7:0] ctrl_b_reg;
    reg  [7:0] x_high_reg;
    reg  [7:0] y_high_reg;
    reg  [3:0] xy_low_reg;

    wire       panel_on   = ctrl_a_reg[`TPR_A_ENABLE];
    wire [2:0] wait_code  = ctrl_a_reg[`TPR_A_WAIT_HI:`TPR_A_WAIT_LO];
    wire       wake_en    = ctrl_a_reg[`TPR_A_WAKE_EN];
    wire [2:0] div_code   = ctrl_a_reg[`TPR_A_DIV_HI:`TPR_A_DIV_LO];
    wire       manual     = ctrl_b_reg[`TPR_B_MANUAL];
    wire       vref_ext   = ctrl_b_reg[`TPR_B_VREF_EXT];
    wire       deb_en     = ctrl_b_reg[`TPR_B_DEBOUNCE];
    wire [1:0] mode_code  = ctrl_b_reg[`TPR_B_MODE_HI:`TPR_B_MODE_LO];
    wire       touched    = ~sense_sync_reg;

    // ------------------------------------------------------------------------
    // ahb-lite slave: writes zero wait, reads one wait state
    // ------------------------------------------------------------------------
    reg                      wr_pend_reg;
    reg                      rd_pend_reg;
    reg  [`TPR_ADDR_W-1:0]   addr_reg;
    reg  [7:0]               rd_mux;
    wire                     addr_phase;
    wire                     wr_go;

    // a read waits one cycle so a write just before it is seen
    assign hreadyout  = ~rd_pend_reg;
    assign hresp      = 1'b0;
    assign addr_phase = hsel & htrans[1] & hready;
    assign wr_go      = wr_pend_reg & ce;

    // address phase capture; hsize is not checked, so any transfer size is taken
    always @(posedge clk or negedge rst_n_sync) begin
        if (!rst_n_sync) begin
            wr_pend_reg <= 1'b0;
            rd_pend_reg <= 1'b0;
            addr_reg    <= {`TPR_ADDR_W{1'b0}};
        end else if (ce) begin
            if (rd_pend_reg) begin
                rd_pend_reg <= 1'b0;
            end else begin
                wr_pend_reg <= addr_phase & hwrite;
                rd_pend_reg <= addr_phase & ~hwrite;
                if (addr_phase) begin
                    addr_reg <= haddr[`TPR_ADDR_W-1:0];
                end
            end
        end
    end

    // read mux; unmapped offsets read zero
    always @* begin
        case (addr_reg)
            `TPR_ADDR_CTRL_A: rd_mux = ctrl_a_reg;
            `TPR_ADDR_CTRL_B: rd_mux = (ctrl_b_reg & `TPR_B_WR_MASK) | `TPR_B_RO_ONES;
            `TPR_ADDR_X_HIGH: rd_mux = x_high_reg;
            `TPR_ADDR_Y_HIGH: rd_mux = y_high_reg;
            `TPR_ADDR_XY_LOW: rd_mux = {sense_sync_reg, 3'h0, xy_low_reg};
            default:          rd_mux = 8'h00;
        endcase
    end

    // read data loaded in the wait cycle
    always @(posedge clk or negedge rst_n_sync) begin
        if (!rst_n_sync) begin
            hrdata <= 32'h00000000;
        end else if (ce && rd_pend_reg) begin
            hrdata <= {24'h000000, rd_mux};
        end
    end

    // ------------------------------------------------------------------------
    // phase sequencer
    // ------------------------------------------------------------------------
    localparam PH_IDLE = `TPR_PH_IDLE;
    localparam PH_WAIT = `TPR_PH_WAIT;
    localparam PH_LATX = `TPR_PH_LATX;
    localparam PH_LATY = `TPR_PH_LATY;

    reg  [1:0] phase_reg;
    reg  [1:0] phase_next;
    reg        start_next;
    wire       smp_done;
    wire       smp_busy;

    // manual follows the code; auto walks wait, x, y
    always @* begin
        phase_next = phase_reg;
        start_next = 1'b0;
        if (!panel_on) begin
            phase_next = PH_IDLE;
        end else if (manual) begin
            phase_next = mode_code;
            // latch entry starts a full wait
            if (mode_code[1] && mode_code != phase_reg) begin
                start_next = 1'b1;
            end
        end else begin
            case (phase_reg)
                PH_IDLE: begin
                    phase_next = PH_WAIT;
                end
                PH_WAIT: begin
                    if (touched) begin
                        phase_next = PH_LATX;
                        start_next = 1'b1;
                    end
                end
                PH_LATX: begin
                    if (smp_done) begin
                        phase_next = PH_LATY;
                        start_next = 1'b1;
                    end
                end
                PH_LATY: begin
                    if (smp_done) begin
                        phase_next = PH_WAIT;
                    end
                end
                default: begin
                    phase_next = PH_IDLE;
                end
            endcase
        end
    end

    reg  start_reg;

    always @(posedge clk or negedge rst_n_sync) begin
        if (!rst_n_sync) begin
            phase_reg <= PH_IDLE;
            start_reg <= 1'b0;
        end else if (ce) begin
            phase_reg <= phase_next;
            start_reg <= start_next;
        end
    end

    tpr_sample_timer #(
        .BASE (WAIT_BASE),
        .W    (`TPR_WAIT_W)
    ) u_timer (
        .clk   (clk),
        .rst_n (rst_n_sync),
        .ce    (ce),
        .start (start_reg),
        .code  (wait_code),
        .busy  (smp_busy),
        .done  (smp_done)
    );

    tpr_adc_clkdiv u_div (
        .clk   (clk),
        .rst_n (rst_n_sync),
        .ce    (ce),
        .run   (smp_busy),
        .code  (div_code),
        .tick  (adc_clk_tick)
    );

    // adc control levels: enable and vref from the registers, run from the timer, axis from the phase
    always @(posedge clk or negedge rst_n_sync) begin
        if (!rst_n_sync) begin
            adc_enable   <= 1'b0;
            adc_run      <= 1'b0;
            adc_axis_y   <= 1'b0;
            adc_vref_ext <= 1'b0;
        end else if (ce) begin
            adc_enable   <= panel_on;
            adc_run      <= smp_busy;
            adc_axis_y   <= (phase_reg == PH_LATY);
            adc_vref_ext <= vref_ext;
        end
    end

    // ------------------------------------------------------------------------
    // register writes and coordinate latching
    // ------------------------------------------------------------------------
    wire lat_x = smp_done & (phase_reg == PH_LATX);
    wire lat_y = smp_done & (phase_reg == PH_LATY);

    // a hardware latch beats a same-cycle write
    always @(posedge clk or negedge rst_n_sync) begin
        if (!rst_n_sync) begin
            ctrl_a_reg <= `TPR_RST_CTRL_A;
            ctrl_b_reg <= `TPR_RST_CTRL_B;
            x_high_reg <= `TPR_RST_COORD;
            y_high_reg <= `TPR_RST_COORD;
            xy_low_reg <= 4'h0;
        end else if (ce) begin
            if (wr_go && addr_reg == `TPR_ADDR_CTRL_A) begin
                ctrl_a_reg <= hwdata[7:0];
            end
            if (wr_go && addr_reg == `TPR_ADDR_CTRL_B) begin
                ctrl_b_reg <= hwdata[7:0] & `TPR_B_WR_MASK;
            end
            if (lat_x) begin
                x_high_reg      <= adc_data[9:2];
                xy_low_reg[1:0] <= adc_data[1:0];
            end else if (wr_go && addr_reg == `TPR_ADDR_X_HIGH) begin
                x_high_reg <= hwdata[7:0];
            end
            if (lat_y) begin
                y_high_reg      <= adc_data[9:2];
                xy_low_reg[3:2] <= adc_data[1:0];
            end else if (wr_go && addr_reg == `TPR_ADDR_Y_HIGH) begin
                y_high_reg <= hwdata[7:0];
            end
            if (wr_go && addr_reg == `TPR_ADDR_XY_LOW) begin
                if (!lat_x) begin
                    xy_low_reg[1:0] <= hwdata[1:0];
                end
                if (!lat_y) begin
                    xy_low_reg[3:2] <= hwdata[3:2];
                end
            end
        end
    end

    // ------------------------------------------------------------------------
    // interrupt path: optional de-bounce, event pulse and wake request
    // ------------------------------------------------------------------------
    localparam DEB_W = 8;

    reg  [DEB_W-1:0] deb_cnt_reg;
    reg              deb_lvl_reg;
    reg              irq_lvl_prev_reg;
    wire             irq_lvl;

    // level must hold for the full count
    always @(posedge clk or negedge rst_n_sync) begin
        if (!rst_n_sync) begin
            deb_cnt_reg <= {DEB_W{1'b0}};
            deb_lvl_reg <= 1'b0;
        end else if (ce) begin
            if (touched == deb_lvl_reg) begin
                deb_cnt_reg <= {DEB_W{1'b0}};
            end else if (deb_cnt_reg == DEBOUNCE_CYC[DEB_W-1:0] - 8'h01) begin
                deb_cnt_reg <= {DEB_W{1'b0}};
                deb_lvl_reg <= touched;
            end else begin
                deb_cnt_reg <= deb_cnt_reg + 8'h01;
            end
        end
    end

    assign irq_lvl = deb_en ? deb_lvl_reg : touched;

    // events only in the wait phase
    always @(posedge clk or negedge rst_n_sync) begin
        if (!rst_n_sync) begin
            irq_lvl_prev_reg <= 1'b0;
            touch_event      <= 1'b0;
            wake_req         <= 1'b0;
        end else if (ce) begin
            irq_lvl_prev_reg <= irq_lvl;
            touch_event      <= irq_lvl & ~irq_lvl_prev_reg & (phase_reg == PH_WAIT);
            wake_req         <= panel_on & wake_en & sleep_mode & irq_lvl;
        end
    end

endmodule // tpr_touch_panel_readout

// *** test/tpr_chk.sv ***
// tpr_chk.sv: port-level assertions for the touch panel readout
`timescale 1ns/1ps
`include "tpr_defines.vh"

module tpr_chk #(
    parameter WAIT_BASE = 4
) (
    input wire logic        clk,
    input wire logic        rstn,
    input wire logic        ce,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [31:0] hwdata,
    input wire logic        hready,
    input wire logic        hreadyout,
    input wire logic        sleep_mode,
    input wire logic        adc_enable,
    input wire logic        adc_run,
    input wire logic        adc_axis_y,
    input wire logic        adc_vref_ext,
    input wire logic        adc_clk_tick,
    input wire logic        touch_event,
    input wire logic        wake_req
);
    // ------------------------------------------------------------------
    // control register shadow
    // ------------------------------------------------------------------
    reg         wr_pend_reg;
    reg  [11:0] wr_addr_reg;
    reg  [7:0]  ctla_reg;
    reg  [7:0]  ctlb_reg;
    reg  [19:0] run_len_reg;

    // run counter stands in for a long repetition
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            wr_pend_reg <= 1'b0;
            wr_addr_reg <= 12'h000;
            ctla_reg    <= 8'h00;
            ctlb_reg    <= 8'h00;
            run_len_reg <= 20'h00000;
        end else if (ce) begin
            wr_pend_reg <= hsel && htrans[1] && hready && hwrite;
            wr_addr_reg <= haddr[11:0];
            if (wr_pend_reg && wr_addr_reg == `TPR_ADDR_CTRL_A)
                ctla_reg <= hwdata[7:0];
            if (wr_pend_reg && wr_addr_reg == `TPR_ADDR_CTRL_B)
                ctlb_reg <= hwdata[7:0] & `TPR_B_WR_MASK;
            run_len_reg <= adc_run ? run_len_reg + 20'h00001 : 20'h00000;
        end
    end

    default clocking tpr_cb @(posedge clk); endclocking
    default disable iff (!rstn);

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    enable_follow_a: assert property (adc_enable == $past(ctla_reg[7]))
        else $error("enable mismatch");
    off_quiet_a: assert property (!ctla_reg[7] && !$past(ctla_reg[7])
        && !$past(ctla_reg[7], 2) |-> !adc_axis_y && !touch_event)
        else $error("busy while off");
    run_length_a: assert property ($fell(adc_run) && ctlb_reg[6]
        |-> {12'h000, run_len_reg} == (WAIT_BASE << ctla_reg[6:4]))
        else $error("wait length");
    wake_gate_a: assert property (wake_req
        |-> $past(ctla_reg[7]) && $past(ctla_reg[3]) && $past(sleep_mode))
        else $error("stray wake");
    tick_space_a: assert property (adc_clk_tick && ctla_reg[2:0] == 3'h2
        |=> (!adc_clk_tick) [*3])
        else $error("tick spacing");
    vref_follow_a: assert property ($stable(ctlb_reg[5]) |-> adc_vref_ext == ctlb_reg[5])
        else $error("vref mismatch");
    idle_quiet_a: assert property (ctlb_reg[6] && ctlb_reg[1:0] == 2'h0
        && $past(ctlb_reg) == ctlb_reg && $past(ctlb_reg, 2) == ctlb_reg
        |-> !adc_axis_y && !touch_event)
        else $error("busy in idle");
    event_phase_a: assert property (touch_event
        |-> !$past(ctlb_reg[6], 2) || $past(ctlb_reg[1:0], 2) == 2'h1)
        else $error("event outside wait");
    event_pulse_a: assert property (touch_event |=> !touch_event)
        else $error("event too long");
    read_wait_a: assert property (!hreadyout |=> hreadyout)
        else $error("wait too long");

    cover property (touch_event);
    cover property ($fell(adc_run) && !ctlb_reg[6]);
    cover property (wake_req);
endmodule // tpr_chk

bind tpr_touch_panel_readout tpr_chk #(.WAIT_BASE(WAIT_BASE)) tpr_chk_i (
    .clk(clk), .rstn(rstn), .ce(ce), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
    .sleep_mode(sleep_mode), .adc_enable(adc_enable), .adc_run(adc_run),
    .adc_axis_y(adc_axis_y), .adc_vref_ext(adc_vref_ext), .adc_clk_tick(adc_clk_tick),
    .touch_event(touch_event), .wake_req(wake_req));

// *** test/tpr_panel_model.sv ***
// tpr_panel_model.sv: resistive panel and adc result model
`timescale 1ns/1ps

module tpr_panel_model (
    input  wire logic       clk,
    input  wire logic       touched,
    input  wire logic [9:0] x_val,
    input  wire logic [9:0] y_val,
    input  wire logic       adc_axis_y,
    input  wire logic       adc_run,
    output wire logic       touch_sense_n,
    output wire logic [9:0] adc_data
);
    logic       run_d;
    logic [9:0] junk = 10'h155;

    // junk outside a conversion exposes stale reads
    always @(posedge clk) begin
        run_d <= adc_run;
        junk  <= ~junk;
    end
    assign touch_sense_n = !touched;  // low while pressed
    assign adc_data      = (adc_run || run_d) ? (adc_axis_y ? y_val : x_val) : junk;
endmodule // tpr_panel_model

// *** test/tb_touch_panel_readout.sv ***
// tb_touch_panel_readout.sv: bench for the touch panel readout
`timescale 1ns/1ps
`include "tpr_defines.vh"

module tb_touch_panel_readout;
    logic        clk = 1'b0;
    logic        rstn = 1'b0;
    logic        hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic        sleep_mode = 1'b0;
    logic        touched = 1'b0;
    logic [9:0]  x_val = 10'h2D6;
    logic [9:0]  y_val = 10'h135;
    logic        run_d = 1'b0;
    wire         hready, hresp, adc_enable, adc_run, adc_axis_y, adc_vref_ext;
    wire         adc_clk_tick, touch_event, wake_req, touch_sense_n;
    wire  [31:0] hrdata;
    wire  [9:0]  adc_data;
    int          n_fail = 0;
    int          total_checks = 0;
    int          n_evt = 0;
    int          n_fall = 0;
    int          e;

    // short wait base and debounce keep the run brief
    tpr_touch_panel_readout #(.WAIT_BASE(4), .DEBOUNCE_CYC(4)) tpr_touch_panel_readout_i (
        .clk(clk), .rstn(rstn), .ce(1'b1), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
        .hreadyout(hready), .hresp(hresp), .hrdata(hrdata), .touch_sense_n(touch_sense_n),
        .sleep_mode(sleep_mode), .adc_data(adc_data), .adc_enable(adc_enable),
        .adc_run(adc_run), .adc_axis_y(adc_axis_y), .adc_vref_ext(adc_vref_ext),
        .adc_clk_tick(adc_clk_tick), .touch_event(touch_event), .wake_req(wake_req));
    tpr_panel_model tpr_panel_model_i (.clk(clk), .touched(touched), .x_val(x_val),
        .y_val(y_val), .adc_axis_y(adc_axis_y), .adc_run(adc_run),
        .touch_sense_n(touch_sense_n), .adc_data(adc_data));

    initial forever #5 clk = ~clk;

    // ------------------------------------------------------------------
    // event and conversion counters
    // ------------------------------------------------------------------
    always @(posedge clk) begin
        run_d <= adc_run;
        if (touch_event === 1'b1) n_evt <= n_evt + 1;
        if (run_d === 1'b1 && adc_run === 1'b0) n_fall <= n_fall + 1;
    end

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        total_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic hang(input string what);
        n_fail++;
        $display("[ERR] %0t timeout %s", $time, what);
        wrap_up();
    endtask

    // ------------------------------------------------------------------
    // ahb-lite single transfers
    // ------------------------------------------------------------------
    task automatic wait_rdy();
        int i = 0;
        do begin
            @(posedge clk);
            i++;
        end while (hready !== 1'b1 && i < 50);
        if (hready !== 1'b1) hang("bus");
    endtask

    task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        @(posedge clk);
        hsel   <= 1'b1;
        htrans <= 2'h2;
        haddr  <= {20'h0, a};
        hwrite <= wr;
        wait_rdy();
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wr ? d : 32'h0;
        wait_rdy();
        q = hrdata;
    endtask

    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        logic [31:0] q;
        bus(1'b1, a, {24'h0, d}, q);
    endtask

    task automatic rd_chk(input logic [11:0] a, input logic [7:0] x, input string w);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        chk(q, {24'h0, x}, w);
    endtask

    // sel 0: conversions, sel 1: events
    task automatic wait_cnt(input logic sel, input int n);
        int t;
        t = (sel ? n_evt : n_fall) + n;
        for (int i = 0; i < 3000 && (sel ? n_evt : n_fall) < t; i++) @(posedge clk);
        if ((sel ? n_evt : n_fall) < t) hang("wait");
    endtask

    task automatic glitch();
        repeat (20) @(posedge clk);
        touched <= 1'b1;
        repeat (2) @(posedge clk);
        touched <= 1'b0;
        repeat (20) @(posedge clk);
    endtask

    initial begin
        repeat (3) @(posedge clk);
        rstn <= 1'b1;
        repeat (5) @(posedge clk);
        rd_chk(`TPR_ADDR_CTRL_A, 8'h00, "ctrl a reset");
        rd_chk(`TPR_ADDR_CTRL_B, 8'h80, "ctrl b reset");
        rd_chk(`TPR_ADDR_X_HIGH, 8'h00, "x high reset");
        rd_chk(`TPR_ADDR_Y_HIGH, 8'h00, "y high reset");
        rd_chk(`TPR_ADDR_XY_LOW, 8'h80, "low reset");
        wr(12'h1D4, 8'hFF);
        rd_chk(12'h1D4, 8'h00, "unmapped");
        wr(`TPR_ADDR_CTRL_B, 8'hBF);
        rd_chk(`TPR_ADDR_CTRL_B, 8'hA7, "ctrl b access");
        chk(adc_vref_ext, 1, "vref ext");
        wr(`TPR_ADDR_X_HIGH, 8'hA5);
        rd_chk(`TPR_ADDR_X_HIGH, 8'hA5, "x high rw");
        wr(`TPR_ADDR_XY_LOW, 8'h7F);
        rd_chk(`TPR_ADDR_XY_LOW, 8'h8F, "low byte access");
        $display("test registers done");
        // manual steps, longest wait, adc clock / 4
        wr(`TPR_ADDR_CTRL_A, 8'hF2);
        wr(`TPR_ADDR_CTRL_B, 8'h41);
        touched <= 1'b1;
        wait_cnt(1'b1, 1);
        rd_chk(`TPR_ADDR_XY_LOW, 8'h0F, "touched flag");
        wr(`TPR_ADDR_CTRL_B, 8'h42);
        wait_cnt(1'b0, 1);
        rd_chk(`TPR_ADDR_X_HIGH, 8'hB5, "x high latch");
        rd_chk(`TPR_ADDR_XY_LOW, 8'h0E, "x low latch");
        wr(`TPR_ADDR_CTRL_B, 8'h43);
        wait_cnt(1'b0, 1);
        rd_chk(`TPR_ADDR_Y_HIGH, 8'h4D, "y high latch");
        rd_chk(`TPR_ADDR_XY_LOW, 8'h06, "y low latch");
        wr(`TPR_ADDR_CTRL_B, 8'h40);
        x_val <= 10'h3FF;
        repeat (40) @(posedge clk);
        rd_chk(`TPR_ADDR_X_HIGH, 8'hB5, "idle holds");
        $display("test manual done");
        // wake needs enable and sleep
        sleep_mode <= 1'b1;
        wr(`TPR_ADDR_CTRL_A, 8'hFA);
        repeat (3) @(posedge clk);
        chk(wake_req, 1, "wake set");
        chk(adc_enable, 1, "enabled");
        wr(`TPR_ADDR_CTRL_A, 8'h72);
        repeat (3) @(posedge clk);
        chk(wake_req, 0, "wake off");
        chk(adc_enable, 0, "disabled");
        sleep_mode <= 1'b0;
        $display("test wake done");
        // de-bounce filters a short glitch
        wr(`TPR_ADDR_CTRL_A, 8'hF2);
        wr(`TPR_ADDR_CTRL_B, 8'h45);
        touched <= 1'b0;
        e = n_evt;
        glitch();
        chk(n_evt, e, "glitch filtered");
        wr(`TPR_ADDR_CTRL_B, 8'h41);
        glitch();
        chk(n_evt, e + 1, "glitch passes");
        $display("test debounce done");
        // auto mode runs x then y
        wr(`TPR_ADDR_CTRL_A, 8'h80);
        x_val <= 10'h0F3;
        y_val <= 10'h2A8;
        wr(`TPR_ADDR_CTRL_B, 8'h00);
        touched <= 1'b1;
        wait_cnt(1'b0, 2);
        rd_chk(`TPR_ADDR_X_HIGH, 8'h3C, "auto x");
        rd_chk(`TPR_ADDR_Y_HIGH, 8'hAA, "auto y");
        rd_chk(`TPR_ADDR_XY_LOW, 8'h03, "auto low");
        $display("test auto done");
        wrap_up();
    end
endmodule // tb_touch_panel_readout
